// File: acs_params.svh
/*
  Constants of the audio clock source selector: clock rate, timeout,
  sample rate codes, source codes and optical channel numbering.
  Assumes it is included by bare name, after the package if needed.
*/
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
// System clock and lock timeout
`define ACS_CLK_HZ 250000000
`define ACS_LOCK_TO_NS 40000
`define ACS_LOCK_TO_CYC (`ACS_LOCK_TO_NS*(`ACS_CLK_HZ/1000000)/1000)
// Sample periods in system clock cycles
`define ACS_P32 (`ACS_CLK_HZ/32000)
`define ACS_P441 (`ACS_CLK_HZ/44100)
`define ACS_P48 (`ACS_CLK_HZ/48000)
`define ACS_P882 (`ACS_CLK_HZ/88200)
`define ACS_P96 (`ACS_CLK_HZ/96000)
`define ACS_P1764 (`ACS_CLK_HZ/176400)
`define ACS_P192 (`ACS_CLK_HZ/192000)
// Rate codes
`define ACS_R32 3'h0
`define ACS_R441 3'h1
`define ACS_R48 3'h2
`define ACS_R882 3'h3
`define ACS_R96 3'h4
`define ACS_R1764 3'h5
`define ACS_R192 3'h6
`define ACS_RNONE 3'h7
// Clock source codes
`define ACS_SRC_INT 3'h0
`define ACS_SRC_WC 3'h1
`define ACS_SRC_AES 3'h2
`define ACS_SRC_OPT1 3'h3
`define ACS_SRC_OPT2 3'h4
// Speed ranges
`define ACS_SPD_SINGLE 2'h0
`define ACS_SPD_DOUBLE 2'h1
`define ACS_SPD_QUAD 2'h2
// Optical port two modes
`define ACS_O2_MULTI 2'h0
`define ACS_O2_SPDIF 2'h1
`define ACS_O2_AES 2'h2
// Optical channel numbering and counts
`define ACS_OPT1_CH0 5'h0f
`define ACS_OPT2_CH0 5'h17
`define ACS_NCH_SINGLE 4'h8
`define ACS_NCH_DOUBLE 4'h4
`define ACS_NCH_QUAD 4'h2
`define ACS_NCH_SPDIF 4'h2
`endif

// File: acs_pkg.sv
/*
  Types of the audio clock source selector: selection states and the
  state records of the system and link clock domains.
  Assumes nothing of its surroundings.
*/
package acs_pkg;
  // Source selection states, Gray along hold-scan-master
  typedef enum logic [1:0] {
    ACS_HOLD = 2'h0,
    ACS_SCAN = 2'h1,
    ACS_MASTER = 2'h3
  } acs_sel_e;

  // System clock domain state
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [3:0] prv;
    logic [3:0][13:0] cnt;
    logic [3:0] lock;
    logic [3:0] sync;
    logic [3:0][2:0] rate;
    acs_sel_e st;
    logic [1:0] idx;
    logic [2:0] cur;
    logic [1:0] spd;
    logic [12:0] tcnt;
    logic tick;
    logic [11:0] wcnt;
    logic wc;
    logic [5:0] hword;
    logic hreq;
    logic [1:0] hack;
    logic rec_in;
    logic rec_out;
    logic loop12;
  } acs_main_s;

  // Link clock domain state
  typedef struct packed {
    logic s1;
    logic s2;
    logic ack;
    logic [5:0] word;
    logic [3:0] n1;
    logic [3:0] n2;
    logic [4:0] last1;
    logic [4:0] last2;
    logic o1_spdif;
    logic o2_spdif;
    logic o2_aes;
    logic loop1;
    logic loop2;
    logic cs_pro;
  } acs_link_s;
endpackage : acs_pkg

// File: acs_selector.sv
/*
  Audio clock source selector: lock and rate monitor of four reference
  inputs, automatic source fallback, internal sample clock, word clock
  output, and optical port formatting in the link clock domain.
  Assumes reference pins are asynchronous frame-rate square waves and
  that configuration ports come from logic on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "acs_params.svh"

// Function
// - Clock comes from internal oscillator or word, AES, optical one, two.
// - Preferred reference stays the source while it carries a valid signal.
// - Preferred reference lost: switch to first valid input, scanning in turn from word clock.
// - Automatic mode keeps scanning and leaves internal clock on valid input.
// - Reference failed and no other input valid, or none valid: run from internal oscillator as master.
// - Report no lock, lock or sync per input, and the source in use.
// - Report coarse detected rate per input as nearest standard frequency.
// - Word clock out at current rate, or base rate with option set.
// - Without option, word clock in is accepted at base of speed range.
// - With option, internal rate follows word clock over all speeds.
// - Optical one: eight channels 15-22, or SPDIF on 15/16.
// - Optical two: eight channels 23-30, or SPDIF on 23/24.
// - Optical two in AES mode carries the AES output as SPDIF.
// - AES input from XLR, or from optical two input when selected.
// - AES status professional or consumer, also on optical two AES.
// - At 88.2/96 kHz optical ports use two-way multiplexing, four channels.
// - At 176.4/192 kHz optical ports use four-way multiplexing, two channels.
// - Record processing uses input channel, or output channel on loopback.
// - Loopback on outputs 1/2 returns them to inputs 1/2 undelayed.
module acs_selector #(
  parameter logic [13:0] LOCK_TIMEOUT = 14'(`ACS_LOCK_TO_CYC)
) (
  // Clocks and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_clk,
  // Reference pins
  input wire logic wc_in,
  input wire logic aes_xlr_in,
  input wire logic opt1_in,
  input wire logic opt2_in,
  // Configuration
  input wire logic [2:0] pref_src,
  input wire logic [2:0] int_rate,
  input wire logic base_rate_opt,
  input wire logic aes_src_opt2,
  input wire logic aes_pro,
  input wire logic opt1_spdif,
  input wire logic [1:0] opt2_mode,
  input wire logic rec_proc_en,
  input wire logic loop12_en,
  // Status
  output logic [3:0] lock_q,
  output logic [3:0] sync_q,
  output logic [11:0] rate_q,
  output logic [2:0] cur_src_q,
  output logic master_q,
  output logic [1:0] speed_q,
  output logic sample_tick_q,
  output logic wc_out_q,
  output logic rec_from_in_q,
  output logic rec_from_out_q,
  output logic loop12_q,
  // Optical outputs, link clock domain
  output logic [3:0] opt1_nch_q,
  output logic [4:0] opt1_last_q,
  output logic opt1_spdif_q,
  output logic opt1_loop_only_q,
  output logic [3:0] opt2_nch_q,
  output logic [4:0] opt2_last_q,
  output logic opt2_spdif_q,
  output logic opt2_from_aes_q,
  output logic opt2_loop_only_q,
  output logic cs_pro_q
);
  import acs_pkg::*;

  acs_main_s q, d;
  acs_link_s lq, ld;
  logic [3:0] refs;
  logic [2:0] cr;
  logic [2:0] wr;
  logic pref_ok;

  // Nearest standard rate for a measured period, none if out of range
  function automatic logic [2:0] cls(input logic [13:0] p);
    logic [31:0] w;
    w = {18'h0, p};
    if (w > `ACS_P32 + `ACS_P32 / 8) cls = `ACS_RNONE;
    else if (w > (`ACS_P32 + `ACS_P441) / 2) cls = `ACS_R32;
    else if (w > (`ACS_P441 + `ACS_P48) / 2) cls = `ACS_R441;
    else if (w > (`ACS_P48 + `ACS_P882) / 2) cls = `ACS_R48;
    else if (w > (`ACS_P882 + `ACS_P96) / 2) cls = `ACS_R882;
    else if (w > (`ACS_P96 + `ACS_P1764) / 2) cls = `ACS_R96;
    else if (w > (`ACS_P1764 + `ACS_P192) / 2) cls = `ACS_R1764;
    else if (w >= `ACS_P192 - `ACS_P192 / 8) cls = `ACS_R192;
    else cls = `ACS_RNONE;
  endfunction : cls

  // Sample period in cycles for a rate code
  function automatic logic [12:0] per(input logic [2:0] r);
    case (r)
      `ACS_R32: per = 13'(`ACS_P32);
      `ACS_R441: per = 13'(`ACS_P441);
      `ACS_R882: per = 13'(`ACS_P882);
      `ACS_R96: per = 13'(`ACS_P96);
      `ACS_R1764: per = 13'(`ACS_P1764);
      `ACS_R192: per = 13'(`ACS_P192);
      default: per = 13'(`ACS_P48);
    endcase
  endfunction : per

  // Speed range of a rate code
  function automatic logic [1:0] spd(input logic [2:0] r);
    if (r == `ACS_R1764 || r == `ACS_R192) spd = `ACS_SPD_QUAD;
    else if (r == `ACS_R882 || r == `ACS_R96) spd = `ACS_SPD_DOUBLE;
    else spd = `ACS_SPD_SINGLE;
  endfunction : spd

  // Single speed equivalent of a rate code
  function automatic logic [2:0] base(input logic [2:0] r);
    if (r == `ACS_R882 || r == `ACS_R1764) base = `ACS_R441;
    else if (r == `ACS_R96 || r == `ACS_R192) base = `ACS_R48;
    else base = r;
  endfunction : base

  // Lock of a source code; internal never counts as a reference
  function automatic logic lk(input logic [3:0] l, input logic [2:0] s);
    if (s == `ACS_SRC_INT || s > `ACS_SRC_OPT2) lk = 1'b0;
    else lk = l[2'(s - 3'h1)];
  endfunction : lk

  // Channel count on an optical port for a speed range
  function automatic logic [3:0] nch(input logic sp, input logic [1:0] s);
    if (sp) nch = `ACS_NCH_SPDIF;
    else if (s == `ACS_SPD_QUAD) nch = `ACS_NCH_QUAD;
    else if (s == `ACS_SPD_DOUBLE) nch = `ACS_NCH_DOUBLE;
    else nch = `ACS_NCH_SINGLE;
  endfunction : nch

  // Reference lines after synchronisers; AES may come from optical two
  assign refs = {q.s2[3], q.s2[2], aes_src_opt2 ? q.s2[4] : q.s2[1],
                 q.s2[0]};
  assign pref_ok = lk(q.lock, pref_src);

  // Active rate: word clock without option keeps internal range
  always_comb begin
    if (q.cur == `ACS_SRC_INT) cr = int_rate;
    else if (q.cur == `ACS_SRC_WC && !base_rate_opt) cr = int_rate;
    else cr = q.rate[2'(q.cur - 3'h1)];
    wr = base_rate_opt ? base(cr) : cr;
  end

  // System domain next state
  always_comb begin
    d = q;
    d.s1 = {opt2_in, opt2_in, opt1_in, aes_xlr_in, wc_in};
    d.s2 = q.s1;
    d.prv = refs;
    // Period measurement, lock and coarse rate per reference
    for (int i = 0; i < 4; i++) begin
      if (refs[i] && !q.prv[i]) begin
        d.rate[i] = cls(q.cnt[i]);
        d.lock[i] = (cls(q.cnt[i]) != `ACS_RNONE);
        d.cnt[i] = 14'h1;
      end else if (q.cnt[i] >= LOCK_TIMEOUT) begin
        d.lock[i] = 1'b0;
        d.rate[i] = `ACS_RNONE;
      end else begin
        d.cnt[i] = q.cnt[i] + 14'h1;
      end
      // Sync: locked and at the rate the unit runs at, word clock at its base rate without option
      d.sync[i] = q.lock[i] && q.rate[i] ==
        ((i == 0 && !base_rate_opt) ? base(cr) : cr);
    end
    // Source selection
    case (q.st)
      ACS_HOLD: begin
        if (pref_ok && q.cur != pref_src) begin
          d.cur = pref_src;
        end else if (!lk(q.lock, q.cur)) begin
          d.st = ACS_SCAN;
          d.idx = 2'h0;
        end
      end
      ACS_SCAN: begin
        if (pref_ok) begin
          d.cur = pref_src;
          d.st = ACS_HOLD;
        end else if (q.lock[q.idx]) begin
          d.cur = {1'b0, q.idx} + 3'h1;
          d.st = ACS_HOLD;
        end else if (q.idx == 2'h3) begin
          d.cur = `ACS_SRC_INT;
          d.st = ACS_MASTER;
        end else begin
          d.idx = q.idx + 2'h1;
        end
      end
      ACS_MASTER: begin
        // Internal preference pins the unit to master
        d.cur = `ACS_SRC_INT;
        if (pref_src != `ACS_SRC_INT && q.lock != 4'h0) begin
          d.st = ACS_SCAN;
          d.idx = 2'h0;
        end
      end
      default: begin
        d.st = ACS_MASTER;
        d.cur = `ACS_SRC_INT;
      end
    endcase
    d.spd = spd(cr);
    // Sample clock tick from the active rate; free-running, never re-aligned on reference edges
    d.tick = 1'b0;
    if (q.tcnt >= per(cr) - 13'h1) begin
      d.tcnt = 13'h0;
      d.tick = 1'b1;
    end else begin
      d.tcnt = q.tcnt + 13'h1;
    end
    // Word clock output, toggling every half period
    if ({1'b0, q.wcnt} >= per(wr) / 13'h2 - 13'h1) begin
      d.wcnt = 12'h0;
      d.wc = !q.wc;
    end else begin
      d.wcnt = q.wcnt + 12'h1;
    end
    // Handshake to link domain; word held until acknowledged
    d.hack = {q.hack[0], lq.ack};
    if (q.hreq == q.hack[1] &&
        q.hword != {aes_pro, opt2_mode, opt1_spdif, q.spd}) begin
      d.hword = {aes_pro, opt2_mode, opt1_spdif, q.spd};
      d.hreq = !q.hreq;
    end
    // Record path processing and loopback
    d.loop12 = loop12_en;
    d.rec_in = rec_proc_en && !loop12_en;
    d.rec_out = rec_proc_en && loop12_en;
  end

  // System domain registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= ACS_MASTER;
      q.rate <= {4{`ACS_RNONE}};
    end else begin
      q <= d;
    end
  end

  // Link domain next state: optical port format and channel map
  always_comb begin
    ld = lq;
    ld.s1 = q.hreq;
    ld.s2 = lq.s1;
    if (lq.s2 != lq.ack) begin
      ld.word = q.hword;
      ld.ack = lq.s2;
    end
    ld.o1_spdif = lq.word[2];
    ld.o2_spdif = lq.word[4:3] != `ACS_O2_MULTI;
    ld.o2_aes = lq.word[4:3] == `ACS_O2_AES;
    ld.cs_pro = lq.word[5];
    ld.n1 = nch(lq.word[2], lq.word[1:0]);
    ld.n2 = nch(ld.o2_spdif, lq.word[1:0]);
    ld.last1 = `ACS_OPT1_CH0 + {1'b0, ld.n1} - 5'h1;
    ld.last2 = `ACS_OPT2_CH0 + {1'b0, ld.n2} - 5'h1;
    ld.loop1 = lq.word[2];
    ld.loop2 = ld.o2_spdif;
  end

  // Link domain registers
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lq <= '0;
      lq.n1 <= `ACS_NCH_SINGLE;
      lq.n2 <= `ACS_NCH_SINGLE;
      lq.last1 <= `ACS_OPT1_CH0 + 5'h7;
      lq.last2 <= `ACS_OPT2_CH0 + 5'h7;
    end else begin
      lq <= ld;
    end
  end

  // Outputs straight from state registers
  assign lock_q = q.lock;
  assign sync_q = q.sync;
  assign rate_q = q.rate;
  assign cur_src_q = q.cur;
  assign master_q = q.st[1]; // Only the master code has its upper bit set
  assign speed_q = q.spd;
  assign sample_tick_q = q.tick;
  assign wc_out_q = q.wc;
  assign rec_from_in_q = q.rec_in;
  assign rec_from_out_q = q.rec_out;
  assign loop12_q = q.loop12;
  assign opt1_nch_q = lq.n1;
  assign opt1_last_q = lq.last1;
  assign opt1_spdif_q = lq.o1_spdif;
  assign opt1_loop_only_q = lq.loop1;
  assign opt2_nch_q = lq.n2;
  assign opt2_last_q = lq.last2;
  assign opt2_spdif_q = lq.o2_spdif;
  assign opt2_from_aes_q = lq.o2_aes;
  assign opt2_loop_only_q = lq.loop2;
  assign cs_pro_q = lq.cs_pro;

  // Checks on the system domain, and two on the link domain
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_all_lost;
    (q.lock == 4'h0) [*6];
  endsequence

  a_master_fallback: assert property (s_all_lost |-> cur_src_q == 3'h0)
    else $error("no reference locked but not on internal clock");
  a_pref_kept: assert property (
    (pref_ok && pref_src != 3'h0) [*3] |-> cur_src_q == pref_src)
    else $error("valid preferred reference not in use");
  // The new source must have been locked when the choice was made
  a_fallback_lock: assert property (
    $changed(cur_src_q) && cur_src_q != 3'h0
    |-> lk($past(q.lock), cur_src_q))
    else $error("switched to a reference without lock");
  a_sync_lock: assert property ((sync_q & ~$past(lock_q)) == 4'h0)
    else $error("sync shown without lock");
  a_nolock_rate: assert property (!lock_q[0] |-> rate_q[2:0] == 3'h7)
    else $error("rate reported without lock");
  a_lock_timeout: assert property (
    q.cnt[1] >= LOCK_TIMEOUT && !(refs[1] && !q.prv[1]) |=> !lock_q[1])
    else $error("lock kept past timeout");
  a_rec_loop: assert property (
    rec_proc_en && loop12_en
    |=> rec_from_out_q && !rec_from_in_q && loop12_q)
    else $error("record processing not taken from output");
  // A half period is hundreds of cycles, so a fresh high level must stay
  a_wc_toggle: assert property (
    $rose(wc_out_q) && $stable(wr) |=> wc_out_q [*2])
    else $error("word clock output toggled too fast");
  a_opt_mux: assert property (@(posedge link_clk) disable iff (!rst_n)
    lq.word[1:0] == 2'h2 && !lq.word[2] |=> opt1_nch_q == 4'h2)
    else $error("quad speed optical port not at two channels");
  a_opt_smux: assert property (@(posedge link_clk) disable iff (!rst_n)
    lq.word[1:0] == 2'h1 && !lq.word[2] |=> opt1_nch_q == 4'h4)
    else $error("double speed optical port not at four channels");
endmodule : acs_selector
`default_nettype wire

// File: acs_ref_model.sv
/*
  Partner model: the external devices that feed four reference clocks.
  Assumes the bench gives each half period in ns, zero for no signal.
*/
`timescale 1ns/1ns
`default_nettype none
module acs_ref_model (
  // Half period of each source in ns: word, AES, optical one, two
  input wire logic [3:0][15:0] half_ns,
  // Reference pins
  output var logic [3:0] ref_o
);
  // One generator per source; a silent source rests low like an
  // unplugged cable, so no stale edge can keep a lock alive
  for (genvar g = 0; g < 4; g++) begin : gen_src
    always begin
      if (half_ns[g] > 16'h0) begin
        #(half_ns[g]);
        ref_o[g] = ~ref_o[g];
      end else begin
        ref_o[g] = 1'b0;
        #100;
      end
    end
  end
endmodule : acs_ref_model
`default_nettype wire

// File: acs_selector_tb.sv
/*
  Self-checking bench of the audio clock source selector.
  Assumes the design files and acs_ref_model.sv are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "acs_params.svh"
module acs_selector_tb;
  import acs_pkg::*;
  logic clock = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
  logic [2:0] pref_src = 3'h0, int_rate = 3'h2;
  logic [1:0] opt2_mode = 2'h0;
  logic base_rate_opt = 1'b0, aes_pro = 1'b0, opt1_spdif = 1'b0;
  logic aes_src_opt2 = 1'b0;
  logic rec_proc_en = 1'b0, loop12_en = 1'b0;
  logic [3:0][15:0] half_ns = '0;
  logic [3:0] ref_w, lock_q, sync_q, opt1_nch_q, opt2_nch_q;
  logic [11:0] rate_q;
  logic [2:0] cur_src_q;
  logic [1:0] speed_q;
  logic [4:0] opt1_last_q, opt2_last_q;
  logic master_q, sample_tick_q, wc_out_q, rec_from_in_q, rec_from_out_q;
  logic loop12_q, opt1_spdif_q, opt1_loop_only_q, opt2_spdif_q;
  logic opt2_from_aes_q, opt2_loop_only_q, cs_pro_q;
  int err_total = 0, cmp_count = 0, n;

  // System clock 4 ns; link clock 30 ns, phase unrelated
  always #2 clock = ~clock;
  always #15 link_clk = ~link_clk;

  acs_ref_model acs_ref_model_inst (.half_ns(half_ns), .ref_o(ref_w));
  acs_selector acs_selector_inst (
    .clock(clock), .rst_n(rst_n), .link_clk(link_clk),
    .wc_in(ref_w[0]), .aes_xlr_in(ref_w[1]), .opt1_in(ref_w[2]),
    .opt2_in(ref_w[3]), .pref_src(pref_src), .int_rate(int_rate),
    .base_rate_opt(base_rate_opt), .aes_src_opt2(aes_src_opt2),
    .aes_pro(aes_pro), .opt1_spdif(opt1_spdif), .opt2_mode(opt2_mode),
    .rec_proc_en(rec_proc_en), .loop12_en(loop12_en), .lock_q(lock_q),
    .sync_q(sync_q), .rate_q(rate_q), .cur_src_q(cur_src_q),
    .master_q(master_q), .speed_q(speed_q), .sample_tick_q(sample_tick_q),
    .wc_out_q(wc_out_q), .rec_from_in_q(rec_from_in_q),
    .rec_from_out_q(rec_from_out_q), .loop12_q(loop12_q),
    .opt1_nch_q(opt1_nch_q), .opt1_last_q(opt1_last_q),
    .opt1_spdif_q(opt1_spdif_q), .opt1_loop_only_q(opt1_loop_only_q),
    .opt2_nch_q(opt2_nch_q), .opt2_last_q(opt2_last_q),
    .opt2_spdif_q(opt2_spdif_q), .opt2_from_aes_q(opt2_from_aes_q),
    .opt2_loop_only_q(opt2_loop_only_q), .cs_pro_q(cs_pro_q));

  // Speed range of a rate code; code 7 runs as 48 kHz
  function automatic logic [1:0] spd_of(input logic [2:0] r);
    return (r inside {3'h3, 3'h4}) ? `ACS_SPD_DOUBLE :
      (r inside {3'h5, 3'h6}) ? `ACS_SPD_QUAD : `ACS_SPD_SINGLE;
  endfunction : spd_of

  // Expected port record: count, last channel, stereo flag, loop only
  function automatic logic [10:0] port_of(input logic [2:0] r,
      input logic sp, input logic [4:0] c0);
    logic [3:0] k;
    k = sp ? `ACS_NCH_SPDIF : (spd_of(r) == `ACS_SPD_DOUBLE) ?
      `ACS_NCH_DOUBLE : (spd_of(r) == `ACS_SPD_QUAD) ?
      `ACS_NCH_QUAD : `ACS_NCH_SINGLE;
    return {k, 5'(c0 + 5'(k) - 5'h1), sp, sp};
  endfunction : port_of

  // Measured periods may differ by a cycle or two of rounding
  function automatic logic near(input int a, input int b);
    return (a >= b - 2) && (a <= b + 2);
  endfunction : near

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // Inputs change 1 ns after the rising edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc

  // Bounded wait for the selector to settle on a source
  task automatic wait_src(input logic [2:0] s);
    int i;
    for (i = 0; i < 40000 && cur_src_q !== s; i++)
      cyc(1);
    if (i == 40000) begin
      err_total++;
      stop_test();
    end
  endtask : wait_src

  // Cycles between two rising edges of tick (w=0) or word clock (w=1)
  task automatic period(input bit w, output int p);
    logic prv, s;
    int e;
    e = 0;
    p = 0;
    prv = 1'b1;
    for (int i = 0; i < 30000 && e < 2; i++) begin
      cyc(1);
      s = w ? wc_out_q : sample_tick_q;
      if (e == 1)
        p++;
      if (s === 1'b1 && prv === 1'b0)
        e++;
      prv = s;
    end
    if (e < 2) begin
      err_total++;
      stop_test();
    end
  endtask : period

  // Main sequence
  initial begin
    void'($urandom(32'hca9f4863));
    repeat (10) @(posedge clock);
    #1 rst_n = 1'b1;
    cyc(60);
    chk({master_q, cur_src_q, rate_q}, {1'b1, `ACS_SRC_INT, 12'hfff});
    chk({opt1_nch_q, opt1_last_q, opt2_nch_q, opt2_last_q},
      {4'h8, 5'h16, 4'h8, 5'h1e});
    // Rate codes 0 to 6, then random rates; ports, modes and preferences random throughout
    for (int t = 0; t < 14; t++) begin
      int_rate = (t < 7) ? t[2:0] : 3'($urandom_range(6));
      pref_src = 3'($urandom_range(4));
      opt2_mode = 2'($urandom_range(2));
      {opt1_spdif, aes_pro, rec_proc_en, loop12_en} = 4'($urandom);
      cyc(100);
      chk(speed_q, spd_of(int_rate));
      chk({master_q, cur_src_q}, {1'b1, `ACS_SRC_INT});
      chk({opt1_nch_q, opt1_last_q, opt1_spdif_q, opt1_loop_only_q},
        port_of(int_rate, opt1_spdif, `ACS_OPT1_CH0));
      // AES copy on optical two is a stereo stream as well
      chk({opt2_nch_q, opt2_last_q, opt2_spdif_q, opt2_loop_only_q},
        port_of(int_rate, opt2_mode != `ACS_O2_MULTI,
        `ACS_OPT2_CH0));
      chk({opt2_from_aes_q, cs_pro_q},
        {opt2_mode == `ACS_O2_AES, aes_pro});
      chk({rec_from_in_q, rec_from_out_q, loop12_q}, {rec_proc_en &
        ~loop12_en, rec_proc_en & loop12_en, loop12_en});
    end
    // Word clock output: running rate, then base rate at 96 kHz
    pref_src = `ACS_SRC_WC;
    int_rate = `ACS_R96;
    period(1'b0, n);
    chk(near(n, `ACS_P96), 1);
    period(1'b1, n);
    chk(near(n, `ACS_P96), 1);
    base_rate_opt = 1'b1;
    period(1'b1, n);
    chk(near(n, `ACS_P48), 1);
    base_rate_opt = 1'b0;
    // AES at 48 kHz and optical one at 44.1 kHz, word preferred but dead
    int_rate = `ACS_R48;
    half_ns[1] = 16'd10417;
    half_ns[2] = 16'd11338;
    wait_src(`ACS_SRC_AES);
    cyc(12000);
    chk({lock_q, sync_q, master_q}, 9'h0c4);
    chk(rate_q, {`ACS_RNONE, `ACS_R441, `ACS_R48, `ACS_RNONE});
    chk(cur_src_q, `ACS_SRC_AES);
    pref_src = `ACS_SRC_OPT1;
    wait_src(`ACS_SRC_OPT1);
    cyc(3000);
    chk(cur_src_q, `ACS_SRC_OPT1);
    // Lose the preferred source, then the last one
    half_ns[2] = 16'h0;
    wait_src(`ACS_SRC_AES);
    chk(lock_q, 4'h2);
    half_ns[1] = 16'h0;
    wait_src(`ACS_SRC_INT);
    chk({master_q, lock_q}, 5'h10);
    // Word clock at base rate of double speed, then following 192 kHz
    int_rate = `ACS_R96;
    pref_src = `ACS_SRC_WC;
    half_ns[0] = 16'd10417;
    wait_src(`ACS_SRC_WC);
    cyc(20);
    chk({sync_q[0], speed_q, rate_q[2:0]},
      {1'b1, `ACS_SPD_DOUBLE, `ACS_R48});
    base_rate_opt = 1'b1;
    half_ns[0] = 16'd2604;
    cyc(9000);
    chk({speed_q, rate_q[2:0]}, {`ACS_SPD_QUAD, `ACS_R192});
    // AES reference from optical two: a live XLR line must be ignored
    aes_src_opt2 = 1'b1;
    half_ns[1] = 16'd2604;
    cyc(4000);
    chk(lock_q[1], 1'b0);
    half_ns[3] = 16'd2604;
    cyc(4000);
    chk({lock_q[3], lock_q[1], rate_q[5:3]}, {2'h3, `ACS_R192});
    stop_test();
  end
endmodule : acs_selector_tb
`default_nettype wire
